// ### hw/gpx_expander.sv
// I2C-controlled eight-bit general-purpose I/O expander
//
// Contract
// RULE1: One eight-pin port, each pin input or output
// RULE2: Pin direction follows host-written configuration bit
// RULE3: Input and output values held in registers
// RULE4: Polarity bit inverts input value on read
// RULE5: Every register can be read back
// RULE6: Open-drain low interrupt when input differs stored
// RULE7: Reset loads defaults and clears bus state
// RULE8: All pins are inputs after reset
// RULE9: Three select pins set low address bits
// RULE10: Serial clock from zero to 400 kHz
// RULE11: Command byte selects register for data bytes
// RULE12: Interrupt clears on input read or return
`timescale 1ns/1ps
`include "gpx_consts.svh"
module gpx_expander #(
    parameter logic [3:0] ADDR_BASE = `GPX_ADDR_BASE
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // I2C bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_B,
    // Address select straps
    input wire logic ADDR_SELECT_BIT0,
    input wire logic ADDR_SELECT_BIT1,
    input wire logic ADDR_SELECT_BIT2,
    // Port pins
    input wire logic [7:0] GPIO_IN,
    output gpx_pkg::gpx_drive_t GPIO_DRV,
    // Interrupt, open drain
    output logic INT_OUT,
    output logic INT_OE_B
);
    import gpx_pkg::*;

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [7:0] pin_m, pin_s;
    logic [2:0] asel_m, asel_s;

    // Every MCLK-side decision waits two flops; 50 cycles per bit at top rate
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            pin_m <= 8'h00;
            pin_s <= 8'h00;
            asel_m <= 3'h0;
            asel_s <= 3'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_d} <= {SCL_IN, scl_m, scl_s}; // RULE10
            {sda_m, sda_s, sda_d} <= {SDA_IN, sda_m, sda_s};
            pin_m <= GPIO_IN;
            pin_s <= pin_m;
            asel_m <= {ADDR_SELECT_BIT2, ADDR_SELECT_BIT1, ADDR_SELECT_BIT0};
            asel_s <= asel_m;
        end
    end

    // ----------------------------------------
    // Bus event decode
    // ----------------------------------------
    gpx_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] rx, tx, cmd, in_reg;
    logic rw, nack;
    gpx_drive_t drv;
    logic [7:0] pol;

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
    wire byte_done = (bitcnt == `GPX_BITS_PER_BYTE);
    wire rx_phase = (st == GPX_ADDR) || (st == GPX_CMD) || (st == GPX_WR) || (st == GPX_RD);
    wire addr_hit = (rx[7:1] == {ADDR_BASE, asel_s}); // RULE9
    wire wr_stb = scl_fall && (st == GPX_WR) && byte_done; // RULE11
    wire ld_rd = scl_fall && (((st == GPX_AACK) && rw) || ((st == GPX_RACK) && !nack));
    wire ld_in = ld_rd && (cmd == `GPX_CMD_IN);
    wire [7:0] pin_view = pin_s ^ pol; // RULE4
    wire [7:0] rd_val = (cmd == `GPX_CMD_IN) ? pin_view :
                        (cmd == `GPX_CMD_OUT) ? drv.level :
                        (cmd == `GPX_CMD_POL) ? pol :
                        (cmd == `GPX_CMD_CFG) ? drv.oe_b : 8'h00; // RULE5

    // ----------------------------------------
    // Bus slave state machine
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st <= GPX_IDLE; // RULE7
            bitcnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            cmd <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            SDA_OE_B <= 1'b1;
        end
        else if (start_c)
        begin
            st <= GPX_ADDR;
            bitcnt <= 4'h0;
            SDA_OE_B <= 1'b1;
        end
        else if (stop_c)
        begin
            st <= GPX_IDLE;
            SDA_OE_B <= 1'b1;
        end
        else
        begin
            if (scl_rise && rx_phase)
            begin
                rx <= {rx[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
            end
            if (scl_rise && (st == GPX_RACK))
                nack <= sda_s;
            if (scl_fall)
            begin
                unique case (st)
                    GPX_IDLE:
                        st <= GPX_IDLE;
                    GPX_ADDR:
                        if (byte_done)
                        begin
                            st <= addr_hit ? GPX_AACK : GPX_IDLE;
                            SDA_OE_B <= !addr_hit;
                            rw <= rx[`GPX_RW_BIT];
                        end
                    GPX_AACK, GPX_RACK:
                    begin
                        bitcnt <= 4'h0;
                        if (ld_rd)
                        begin
                            st <= GPX_RD;
                            tx <= rd_val;
                            SDA_OE_B <= rd_val[7];
                        end
                        else
                        begin
                            st <= (st == GPX_AACK) ? GPX_CMD : GPX_IDLE;
                            SDA_OE_B <= 1'b1;
                        end
                    end
                    GPX_CMD:
                        if (byte_done)
                        begin
                            cmd <= rx; // RULE11
                            st <= GPX_CACK;
                            SDA_OE_B <= 1'b0;
                        end
                    GPX_CACK, GPX_WACK:
                    begin
                        st <= GPX_WR;
                        bitcnt <= 4'h0;
                        SDA_OE_B <= 1'b1;
                    end
                    GPX_WR:
                        if (byte_done)
                        begin
                            st <= GPX_WACK;
                            SDA_OE_B <= 1'b0;
                        end
                    GPX_RD:
                        if (byte_done)
                        begin
                            st <= GPX_RACK;
                            SDA_OE_B <= 1'b1;
                        end
                        else
                        begin
                            tx <= {tx[6:0], 1'b0};
                            SDA_OE_B <= tx[6];
                        end
                    default:
                        st <= GPX_IDLE;
                endcase
            end
        end
    end

    // Open-drain lines only ever pull low
    assign SDA_OUT = 1'b0;
    assign INT_OUT = 1'b0;

    // ----------------------------------------
    // Port registers
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            drv.level <= `GPX_OUT_RST; // RULE7
            drv.oe_b <= `GPX_CFG_RST; // RULE8
            pol <= `GPX_POL_RST;
            in_reg <= `GPX_IN_RST;
        end
        else
        begin
            if (wr_stb && (cmd == `GPX_CMD_OUT))
                drv.level <= rx; // RULE3
            if (wr_stb && (cmd == `GPX_CMD_POL))
                pol <= rx;
            if (wr_stb && (cmd == `GPX_CMD_CFG))
                drv.oe_b <= rx; // RULE2
            if (ld_in)
                in_reg <= pin_s; // RULE12
        end
    end
    assign GPIO_DRV = drv; // RULE1

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    logic [7:0] diff;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            // Only pins set as inputs may raise the interrupt
            assign diff[gi] = drv.oe_b[gi] & (pin_s[gi] ^ in_reg[gi]); // RULE1
        end
    endgenerate

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            INT_OE_B <= 1'b1;
        else
            INT_OE_B <= ~|diff; // RULE6
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic cfg_written;
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            cfg_written <= 1'b0;
        else if (wr_stb && (cmd == `GPX_CMD_CFG))
            cfg_written <= 1'b1;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence s_addr_ok;
        scl_fall && (st == GPX_ADDR) && byte_done && addr_hit;
    endsequence
    sequence s_byte_in;
        wr_stb;
    endsequence

    AST_DIR: assert property (wr_stb && (cmd == `GPX_CMD_CFG) |=> GPIO_DRV.oe_b == $past(rx)) // RULE2
        else $error("Direction not taken from written byte");
    AST_OUT: assert property (wr_stb && (cmd == `GPX_CMD_OUT) |=> GPIO_DRV.level == $past(rx)) // RULE3
        else $error("Output register not updated");
    AST_POL: assert property (ld_in |=> tx == ($past(pin_s) ^ $past(pol))) // RULE4
        else $error("Input read ignores polarity");
    AST_RDBACK: assert property (ld_rd && (cmd == `GPX_CMD_CFG) |=> tx == $past(drv.oe_b)) // RULE5
        else $error("Configuration read back wrong");
    AST_INT: assert property ($rose(|diff) |=> !INT_OE_B) // RULE6
        else $error("Interrupt not raised on input change");
    AST_INTCLR: assert property (ld_in ##1 $stable(pin_s) |=> INT_OE_B) // RULE12
        else $error("Interrupt not cleared by input read");
    AST_INPUTS: assert property (!cfg_written |-> GPIO_DRV.oe_b == `GPX_CFG_RST) // RULE8
        else $error("Pin driven before configuration write");
    AST_ADDR: assert property (s_addr_ok |=> !SDA_OE_B && (st == GPX_AACK)) // RULE9
        else $error("Matching address not acknowledged");
    AST_ACK: assert property (s_byte_in |=> !SDA_OE_B ##1 (st == GPX_WACK)) // RULE11
        else $error("Written byte not acknowledged");
    AST_START: assert property (start_c |=> (st == GPX_ADDR) && SDA_OE_B) // RULE7
        else $error("Start condition did not restart slave");
endmodule // gpx_expander

// ### hw/gpx_consts.svh
// Constants for the eight-bit I2C port expander
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH
// ----------------------------------------
// Command bytes (register select)
// ----------------------------------------
`define GPX_CMD_IN 8'h00
`define GPX_CMD_OUT 8'h01
`define GPX_CMD_POL 8'h02
`define GPX_CMD_CFG 8'h03
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define GPX_OUT_RST 8'hff
`define GPX_POL_RST 8'h00
`define GPX_CFG_RST 8'hff
`define GPX_IN_RST 8'h00
`define GPX_ADDR_BASE 4'h4
`define GPX_RW_BIT 0
`define GPX_BITS_PER_BYTE 4'h8
// ----------------------------------------
// Timing
// ----------------------------------------
`define GPX_MCLK_KHZ 20000
`define GPX_SCL_MAX_KHZ 400
`define GPX_MCLK_PER_SCL (`GPX_MCLK_KHZ / `GPX_SCL_MAX_KHZ)
`endif

// ### hw/gpx_pkg.sv
// Types shared by the port expander
package gpx_pkg;
    // Bus slave states, Gray coded along the usual path
    typedef enum logic [3:0] {
        GPX_IDLE = 4'h0,
        GPX_ADDR = 4'h1,
        GPX_AACK = 4'h3,
        GPX_CMD = 4'h2,
        GPX_CACK = 4'h6,
        GPX_WR = 4'h7,
        GPX_WACK = 4'h5,
        GPX_RD = 4'h4,
        GPX_RACK = 4'hc
    } gpx_state_t;

    // Pin drive: level and open-drain style enable (low = driven)
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe_b;
    } gpx_drive_t;
endpackage

// ### verification/gpx_i2c_host.sv
// I2C bus host model for the port expander
`timescale 1ns/1ps
`include "gpx_consts.svh"
module gpx_i2c_host (
    // Clock
    input wire logic MCLK,
    // Device drive of the data line
    input wire logic SDA_OE_B,
    input wire logic SDA_OUT,
    // Bus wires
    output logic SCL,
    output logic SDA
);
    logic sda_drv = 1'b1;
    // Pulled-up wire, low when either side pulls it
    assign SDA = sda_drv & (SDA_OE_B | SDA_OUT);
    initial SCL = 1'b1;
    task hold(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    // 25 cycles a phase: exactly the fast-mode ceiling, never above
    task bit_io(input logic b, output logic r);
        hold(12);
        sda_drv <= b;
        hold(13);
        SCL <= 1'b1;
        hold(12);
        r = SDA;
        hold(13);
        SCL <= 1'b0;
    endtask
    task start_cond;
        hold(12);
        sda_drv <= 1'b1;
        hold(13);
        SCL <= 1'b1;
        hold(25);
        sda_drv <= 1'b0;
        hold(25);
        SCL <= 1'b0;
    endtask
    task stop_cond;
        hold(12);
        sda_drv <= 1'b0;
        hold(13);
        SCL <= 1'b1;
        hold(25);
        sda_drv <= 1'b1;
        hold(25);
    endtask
    task byte_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task byte_rd(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        // Low asks for another byte, high ends the read
        bit_io(~more, r);
    endtask
    task wr_reg(input logic [2:0] sel, input logic [7:0] cmd, input logic [7:0] d,
        output logic ok);
        logic ack_addr, ack_cmd, ack_data;
        start_cond;
        byte_wr({`GPX_ADDR_BASE, sel, 1'b0}, ack_addr);
        byte_wr(cmd, ack_cmd);
        byte_wr(d, ack_data);
        stop_cond;
        ok = ack_addr & ack_cmd & ack_data;
    endtask
    // First byte in d[15:8]; a second one only when two is set
    task rd_reg(input logic [2:0] sel, input logic [7:0] cmd, input logic two,
        output logic [15:0] d, output logic ok);
        logic ack_addr, ack_cmd, ack_read;
        start_cond;
        byte_wr({`GPX_ADDR_BASE, sel, 1'b0}, ack_addr);
        byte_wr(cmd, ack_cmd);
        start_cond;
        byte_wr({`GPX_ADDR_BASE, sel, 1'b1}, ack_read);
        byte_rd(two, d[15:8]);
        d[7:0] = 8'h00;
        if (two)
            byte_rd(1'b0, d[7:0]);
        stop_cond;
        ok = ack_addr & ack_cmd & ack_read;
    endtask
endmodule // gpx_i2c_host

// ### verification/test_gpx_expander.sv
// Self-checking testbench for the I2C port expander
`timescale 1ns/1ps
`include "gpx_consts.svh"
module test_gpx_expander;
    import gpx_pkg::*;
    logic MCLK = 1'b0;
    logic RST_B = 1'b0;
    logic scl, sda, sda_oe_b, sda_out, int_oe_b, int_out, ok;
    logic [2:0] strap = 3'h5;
    logic [7:0] ext = 8'h00;
    logic [7:0] pins;
    logic [15:0] rd;
    gpx_drive_t drv;
    int err_count = 0;
    int cmp_count = 0;
    // Driven pins read back their own level
    assign pins = (drv.oe_b & ext) | (~drv.oe_b & drv.level);
    always #25 MCLK = ~MCLK;
    gpx_expander u_dut (.MCLK(MCLK), .RST_B(RST_B), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_B(sda_oe_b), .ADDR_SELECT_BIT0(strap[0]),
        .ADDR_SELECT_BIT1(strap[1]), .ADDR_SELECT_BIT2(strap[2]), .GPIO_IN(pins),
        .GPIO_DRV(drv), .INT_OUT(int_out), .INT_OE_B(int_oe_b));
    gpx_i2c_host u_host (.MCLK(MCLK), .SDA_OE_B(sda_oe_b), .SDA_OUT(sda_out), .SCL(scl),
        .SDA(sda));
    // ----------------------------------------
    // Checking and access tasks
    // ----------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task int_is(input logic e);
        for (int i = 0; i < 20 && int_oe_b !== e; i++) @(posedge MCLK);
        check({14'h0, int_out, int_oe_b}, {15'h0, e});
    endtask
    task rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
        u_host.rd_reg(3'h5, cmd, 1'b0, rd, ok);
        check({7'h0, ok, rd[15:8]}, {8'h01, exp});
    endtask
    task wr(input logic [7:0] cmd, input logic [7:0] d);
        u_host.wr_reg(3'h5, cmd, d, ok);
        check({15'h0, ok}, 16'h0001);
    endtask
    initial
    begin
        repeat (3) @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge MCLK);
        check(drv, {`GPX_OUT_RST, `GPX_CFG_RST});
        int_is(1'b1);
        rd_chk(`GPX_CMD_OUT, `GPX_OUT_RST);
        rd_chk(`GPX_CMD_POL, `GPX_POL_RST);
        rd_chk(`GPX_CMD_CFG, `GPX_CFG_RST);
        rd_chk(8'h07, 8'h00);
        for (int s = 0; s < 8; s++)
        begin
            strap <= s[2:0];
            u_host.rd_reg(3'h5, `GPX_CMD_POL, 1'b0, rd, ok);
            check({15'h0, ok}, {15'h0, s == 5});
        end
        strap <= 3'h5;
        wr(`GPX_CMD_CFG, 8'h0f);
        wr(`GPX_CMD_OUT, 8'ha5);
        check(drv, 16'ha50f);
        rd_chk(`GPX_CMD_OUT, 8'ha5);
        rd_chk(`GPX_CMD_CFG, 8'h0f);
        // Acknowledged read goes on with the same register
        u_host.rd_reg(3'h5, `GPX_CMD_OUT, 1'b1, rd, ok);
        check({15'h0, ok}, 16'h0001);
        check(rd, 16'ha5a5);
        ext <= 8'h3c;
        int_is(1'b0);
        wr(`GPX_CMD_POL, 8'hff);
        rd_chk(`GPX_CMD_IN, 8'h53);
        int_is(1'b1);
        ext <= 8'h30;
        int_is(1'b0);
        ext <= 8'h3c;
        int_is(1'b1);
        wr(`GPX_CMD_POL, 8'h00);
        rd_chk(`GPX_CMD_IN, 8'hac);
        RST_B <= 1'b0;
        @(posedge MCLK);
        check(drv, {`GPX_OUT_RST, `GPX_CFG_RST});
        check({15'h0, int_oe_b}, 16'h0001);
        @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge MCLK);
        int_is(1'b0);
        rd_chk(`GPX_CMD_CFG, `GPX_CFG_RST);
        complete_run;
    end
    // Run needs about 43k cycles
    initial
    begin
        repeat (60000) @(posedge MCLK);
        err_count++;
        complete_run;
    end
endmodule // test_gpx_expander
